// File: src/efs_stats.sv
/*
 Ethernet frame statistics bank: counts receive and transmit frame
 outcomes and serves snapshot readouts one 32-bit word per cycle.
 Assumes per-frame status strobes are single-cycle and synchronous to
 mclk, and that the readout requester waits for the done pulse before
 asking again.
*/
`timescale 1ns/1ps
// Function
// - Readout returns one consistent captured snapshot
// - Counters wrap to zero; readout never clears
// - 32-bit rx good count, includes dropped good
// - CRC error counted when dribble clear
// - Runt counted: under 64 bytes with CRC
// - Alignment counted: CRC and dribble both set
// - Oversize counted above programmed maximum size
// - Receive late collisions counted
// - Rx bad frames exclude FIFO drops
// - FIFO drops counted, good ones also as good; no error counters
// - 32-bit tx good count, pause excluded
// - Successful pause frames counted
// - Success after exactly one collision counted
// - Success after several collisions counted
// - Aborts on excessive collisions counted
// - Aborts on late collision counted
// - Aborts on buffer underrun counted
// - Aborts on excessive deferral counted
// - Carrier lost or absent counted
// - Errored transmit frames counted
// - Index 0 receive set, 1 transmit
module efs_stats
   import efs_pkg::*;
#(
   parameter int RX_CNT_W = EFS_NARROW_W,
   parameter int TX_CNT_W = EFS_NARROW_W
) (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   // Receive frame status from the receive MAC and rx_fifo_controller
   input  wire logic                          rx_stat_valid,
   input  wire logic                          rx_crc_err,
   input  wire logic                          rx_dribble,
   input  wire logic                          rx_late_col,
   input  wire logic                          rx_other_err,
   input  wire logic                          rx_fifo_drop,
   input  wire logic [efs_pkg::EFS_LEN_BITS-1:0] rx_frame_len,
   input  wire logic [efs_pkg::EFS_LEN_BITS-1:0] rx_max_len,
   // Transmit frame status from the transmit MAC
   input  wire logic                          tx_stat_valid,
   input  wire logic                          tx_ok,
   input  wire logic                          tx_pause,
   input  wire logic [4:0]                    tx_col_cnt,
   input  wire logic                          tx_xs_col,
   input  wire logic                          tx_late_col,
   input  wire logic                          tx_underrun,
   input  wire logic                          tx_xs_defer,
   input  wire logic                          tx_carrier_err,
   // Readout request from bridge_control_logic
   input  wire logic                          rd_req,
   input  wire logic                          rd_set,
   // Readout data stream
   output logic                               rd_valid,
   output logic [efs_pkg::EFS_WORD_W-1:0]     rd_data,
   output logic [efs_pkg::EFS_LEN_W-1:0]      rd_len,
   output logic                               rd_done,
   output logic                               rd_busy
);
   import efs_pkg::*;

   // Receive classification; a dropped frame touches only drop and good counts
   wire rx_ev      = rx_stat_valid;
   wire rx_drop    = rx_ev && rx_fifo_drop;
   wire rx_kept    = rx_ev && !rx_fifo_drop;
   wire rx_crc_only = rx_crc_err && !rx_dribble;
   wire rx_align   = rx_crc_err && rx_dribble;
   wire rx_runt    = rx_crc_err && (rx_frame_len <
                     EFS_LEN_BITS'(EFS_MIN_FRAME));
   wire rx_long    = rx_frame_len > rx_max_len;
   wire rx_any_err = rx_crc_err || rx_long || rx_late_col || rx_other_err;
   wire rx_good    = rx_ev && !rx_any_err;

   wire [EFS_RX_CNT-1:0] rx_inc;
   assign rx_inc[EFS_RX_GOOD]  = rx_good;
   assign rx_inc[EFS_RX_CRC]   = rx_kept && rx_crc_only;
   assign rx_inc[EFS_RX_RUNT]  = rx_kept && rx_runt;
   assign rx_inc[EFS_RX_ALIGN] = rx_kept && rx_align;
   assign rx_inc[EFS_RX_LONG]  = rx_kept && rx_long;
   assign rx_inc[EFS_RX_LATE]  = rx_kept && rx_late_col;
   assign rx_inc[EFS_RX_BAD]   = rx_kept && rx_any_err;
   assign rx_inc[EFS_RX_DROP]  = rx_drop;

   // Transmit classification
   wire tx_ev      = tx_stat_valid;
   wire tx_done_ok = tx_ev && tx_ok;
   wire tx_err     = tx_ev && !tx_ok;
   wire [EFS_TX_CNT-1:0] tx_inc;
   assign tx_inc[EFS_TX_GOOD]  = tx_done_ok && !tx_pause;
   assign tx_inc[EFS_TX_PAUSE] = tx_done_ok && tx_pause;
   assign tx_inc[EFS_TX_SCOL]  = tx_done_ok && (tx_col_cnt == 5'h1);
   assign tx_inc[EFS_TX_MCOL]  = tx_done_ok && (tx_col_cnt > 5'h1);
   assign tx_inc[EFS_TX_XCOL]  = tx_err && tx_xs_col;
   assign tx_inc[EFS_TX_LCOL]  = tx_err && tx_late_col;
   assign tx_inc[EFS_TX_UNDR]  = tx_err && tx_underrun;
   assign tx_inc[EFS_TX_XDEF]  = tx_err && tx_xs_defer;
   assign tx_inc[EFS_TX_CARR]  = tx_ev && tx_carrier_err;
   assign tx_inc[EFS_TX_BAD]   = tx_err;

   // Counter banks; good counters are wide, the rest narrow
   logic [EFS_WORD_W-1:0] rx_val [EFS_NUM_CNT];
   logic [EFS_WORD_W-1:0] tx_val [EFS_NUM_CNT];

   genvar gi;
   generate
      for (gi = 0; gi < EFS_NUM_CNT; gi++) begin : g_cnt
         localparam int RW = (gi == EFS_RX_GOOD) ? EFS_WIDE_W : RX_CNT_W;
         localparam int TW = (gi == EFS_TX_GOOD) ? EFS_WIDE_W : TX_CNT_W;
         logic [TW-1:0] tcnt;
         efs_counter #(.W(TW)) u_tx (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .inc     (tx_inc[gi]),
            .count   (tcnt)
         );
         assign tx_val[gi] = EFS_WORD_W'(tcnt);
         if (gi < EFS_RX_CNT) begin : g_rx
            logic [RW-1:0] rcnt;
            efs_counter #(.W(RW)) u_rx (
               .mclk    (mclk),
               .sys_rst (sys_rst),
               .inc     (rx_inc[gi]),
               .count   (rcnt)
            );
            assign rx_val[gi] = EFS_WORD_W'(rcnt);
         end else begin : g_res
            assign rx_val[gi] = '0; // Reserved receive words read zero
         end
      end
   endgenerate

   // Snapshot store: filled in one edge so the set is consistent
   logic [EFS_WORD_W-1:0] snap [EFS_NUM_CNT];
   efs_state_e            state;
   efs_state_e            next_state;
   logic [EFS_IDX_W-1:0]  idx;
   logic                  set_q;

   wire take    = (state == EFS_IDLE) && rd_req;
   wire [EFS_IDX_W-1:0] last_idx = set_q ?
        EFS_IDX_W'(EFS_TX_LEN >> 2) - 1'b1 :
        EFS_IDX_W'(EFS_RX_LEN >> 2) - 1'b1;
   wire at_last = (state == EFS_SEND) && (idx == last_idx);
   // Transmit words past the ten-entry store read as zero, not unknown
   wire in_store = idx < EFS_IDX_W'(EFS_NUM_CNT);

   // Next state decode
   always_comb begin
      next_state = state;
      case (state)
         EFS_IDLE: if (rd_req) next_state = EFS_SEND;
         EFS_SEND: if (at_last) next_state = EFS_IDLE;
         default:  next_state = EFS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= EFS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Capture every counter of the selected set on the same edge; counting carries on live
   always_ff @(posedge mclk) begin
      if (take) begin
         for (int i = 0; i < EFS_NUM_CNT; i++) begin
            snap[i] <= (rd_set == EFS_SEL_TX) ? tx_val[i] : rx_val[i];
         end
      end
   end

   // Word index and set latch
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         idx   <= '0;
         set_q <= EFS_SEL_RX;
      end else if (take) begin
         idx   <= '0;
         set_q <= rd_set;
      end else if (state == EFS_SEND) begin
         idx   <= idx + 1'b1;
      end
   end

   // Registered outputs: data lags the index by one cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
         rd_len   <= '0;
         rd_done  <= 1'b0;
         rd_busy  <= 1'b0;
      end else begin
         rd_valid <= (state == EFS_SEND);
         rd_data  <= (state == EFS_SEND && in_store) ? snap[idx] : '0;
         rd_done  <= at_last;
         rd_busy  <= (next_state == EFS_SEND);
         if (take) begin
            rd_len <= (rd_set == EFS_SEL_TX) ? EFS_TX_LEN : EFS_RX_LEN;
         end
      end
   end

   // Checks on classification and readout
   drop_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rx_drop |-> !rx_inc[EFS_RX_BAD] && !rx_inc[EFS_RX_CRC])
      else $error("dropped frame reached an error counter");
   crc_align_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(rx_inc[EFS_RX_CRC] && rx_inc[EFS_RX_ALIGN]))
      else $error("crc and alignment counted together");
   pause_good_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(tx_inc[EFS_TX_GOOD] && tx_inc[EFS_TX_PAUSE]))
      else $error("pause frame counted as good");
   col_excl_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(tx_inc[EFS_TX_SCOL] && tx_inc[EFS_TX_MCOL]))
      else $error("single and multiple collision together");
   bad_tx_a: assert property (@(posedge mclk) disable iff (sys_rst)
      tx_inc[EFS_TX_XCOL] |-> tx_inc[EFS_TX_BAD])
      else $error("aborted frame not counted bad");
   rx_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
      take && rd_set == EFS_SEL_RX |=> rd_len == EFS_RX_LEN ##10 rd_done)
      else $error("receive readout length or duration wrong");
   tx_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
      take && rd_set == EFS_SEL_TX |=> rd_len == EFS_TX_LEN ##12 rd_done)
      else $error("transmit readout length or duration wrong");
   snap_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      state == EFS_SEND && !take |=> $stable(snap[0]))
      else $error("snapshot changed during readout");
   valid_busy_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_valid |-> rd_busy || rd_done)
      else $error("valid outside a readout");

   // Classification checked from the raw status pins, except drop_errs_a on rx_drop, so a slip in the
   // decode wires above cannot hide behind its own expression
   drop_errs_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_drop |-> !rx_inc[EFS_RX_RUNT]
      && !rx_inc[EFS_RX_ALIGN] && !rx_inc[EFS_RX_LONG]
      && !rx_inc[EFS_RX_LATE])
      else $error("dropped frame reached a length or collision counter");
   drop_tally_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      rx_stat_valid && rx_fifo_drop |-> rx_inc[EFS_RX_DROP])
      else $error("dropped frame not counted");
   good_rx_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_crc_err && !rx_late_col
      && !rx_other_err && rx_frame_len <= rx_max_len
      |-> rx_inc[EFS_RX_GOOD])
      else $error("clean receive frame not counted good");
   runt_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_fifo_drop && rx_crc_err
      && rx_frame_len < EFS_LEN_BITS'(EFS_MIN_FRAME)
      |-> rx_inc[EFS_RX_RUNT])
      else $error("short frame with bad checksum not counted");
   align_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_fifo_drop && rx_crc_err
      && rx_dribble |-> rx_inc[EFS_RX_ALIGN] && !rx_inc[EFS_RX_CRC])
      else $error("alignment error miscounted");
   long_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_fifo_drop
      && rx_frame_len > rx_max_len
      |-> rx_inc[EFS_RX_LONG] && rx_inc[EFS_RX_BAD])
      else $error("oversize frame miscounted");
   late_rx_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_fifo_drop && rx_late_col
      |-> rx_inc[EFS_RX_LATE] && rx_inc[EFS_RX_BAD])
      else $error("receive late collision miscounted");
   bad_rx_a: assert property (@(posedge mclk)
      disable iff (sys_rst) rx_stat_valid && !rx_fifo_drop && rx_other_err
      |-> rx_inc[EFS_RX_BAD])
      else $error("errored receive frame not counted bad");
   abort_clean_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && !tx_ok
      |-> !tx_inc[EFS_TX_GOOD] && !tx_inc[EFS_TX_PAUSE]
      && !tx_inc[EFS_TX_SCOL] && !tx_inc[EFS_TX_MCOL])
      else $error("aborted frame counted as a success");
   scol_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && tx_ok && tx_col_cnt == 5'h1
      |-> tx_inc[EFS_TX_SCOL])
      else $error("single collision not counted");
   mcol_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && tx_ok && tx_col_cnt > 5'h1
      |-> tx_inc[EFS_TX_MCOL])
      else $error("multiple collision not counted");
   lcol_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && !tx_ok && tx_late_col
      |-> tx_inc[EFS_TX_LCOL] && tx_inc[EFS_TX_BAD])
      else $error("late collision abort miscounted");
   undr_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && !tx_ok && tx_underrun
      |-> tx_inc[EFS_TX_UNDR] && tx_inc[EFS_TX_BAD])
      else $error("underrun abort miscounted");
   xdef_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst) tx_stat_valid && !tx_ok && tx_xs_defer
      |-> tx_inc[EFS_TX_XDEF] && tx_inc[EFS_TX_BAD])
      else $error("deferral abort miscounted");
   carrier_cnt_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      tx_stat_valid && tx_carrier_err |-> tx_inc[EFS_TX_CARR])
      else $error("carrier error not counted");
   take_busy_a: assert property (@(posedge mclk)
      disable iff (sys_rst) take |=> rd_busy && !rd_valid && !rd_done)
      else $error("readout start not signalled");
   refuse_hold_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      state == EFS_SEND && rd_req |=> $stable(rd_len) && $stable(set_q))
      else $error("request during readout was not ignored");
   tail_zero_a: assert property (@(posedge mclk)
      disable iff (sys_rst)
      state == EFS_SEND && !in_store |=> rd_data == '0)
      else $error("word beyond the store not zero");
   idle_data_a: assert property (@(posedge mclk)
      disable iff (sys_rst) !rd_valid |-> rd_data == '0)
      else $error("data not zero outside a readout");

   rx_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
      take && rd_set == EFS_SEL_RX ##11 rd_done);
   tx_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
      take && rd_set == EFS_SEL_TX ##13 rd_done);
   refused_req_c: cover property (@(posedge mclk) disable iff (sys_rst)
      state == EFS_SEND && rd_req);
   drop_err_c: cover property (@(posedge mclk) disable iff (sys_rst)
      rx_drop && rx_crc_err);
   count_in_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
      state == EFS_SEND && rx_good);
endmodule // efs_stats

// File: src/efs_pkg.sv
/*
 Package for the Ethernet frame statistics block: counter widths,
 readout set selectors, readout lengths and snapshot word indices.
 Assumes a single core clock domain and no register bus.
*/
package efs_pkg;
   localparam int EFS_WIDE_W   = 32;          // Good frame counters
   localparam int EFS_NARROW_W = 20;          // Error and event counters
   localparam int EFS_WORD_W   = 32;          // Snapshot word width
   localparam int EFS_NUM_CNT  = 10;          // Snapshot store entries; receive set words
   localparam int EFS_IDX_W    = 4;           // Word index width
   localparam int EFS_LEN_W    = 8;           // Readout length width
   localparam logic EFS_SEL_RX = 1'h0;        // Index bit for receive set
   localparam logic EFS_SEL_TX = 1'h1;        // Index bit for transmit set
   localparam logic [7:0] EFS_RX_LEN = 8'h28; // Receive readout bytes
   localparam logic [7:0] EFS_TX_LEN = 8'h30; // Transmit readout bytes
   localparam int EFS_MIN_FRAME = 64;         // Runt threshold in bytes
   localparam int EFS_LEN_BITS  = 14;         // Frame length field width
   // Receive counter index within the receive set
   localparam int EFS_RX_GOOD  = 0;
   localparam int EFS_RX_CRC   = 1;
   localparam int EFS_RX_RUNT  = 2;
   localparam int EFS_RX_ALIGN = 3;
   localparam int EFS_RX_LONG  = 4;
   localparam int EFS_RX_LATE  = 5;
   localparam int EFS_RX_BAD   = 6;
   localparam int EFS_RX_DROP  = 7;
   // Transmit counter index within the transmit set
   localparam int EFS_TX_GOOD  = 0;
   localparam int EFS_TX_PAUSE = 1;
   localparam int EFS_TX_SCOL  = 2;
   localparam int EFS_TX_MCOL  = 3;
   localparam int EFS_TX_XCOL  = 4;
   localparam int EFS_TX_LCOL  = 5;
   localparam int EFS_TX_UNDR  = 6;
   localparam int EFS_TX_XDEF  = 7;
   localparam int EFS_TX_CARR  = 8;
   localparam int EFS_TX_BAD   = 9;
   localparam int EFS_RX_CNT   = 8;
   localparam int EFS_TX_CNT   = 10;
   typedef enum logic [1:0] {EFS_IDLE, EFS_SEND} efs_state_e;
endpackage

// File: src/efs_counter.sv
/*
 One wrapping statistics counter, cleared by reset only.
 Assumes the increment strobe is a one-cycle pulse per frame.
*/
`timescale 1ns/1ps
module efs_counter #(
   parameter int W = 20
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // Increment strobe and value
   input  wire logic         inc,
   output logic [W-1:0]      count
);
   // Natural binary wrap past all ones; a readout never clears it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (inc) begin
         count <= count + 1'b1;
      end
   end

   wrap_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      inc && (&count) |=> count == '0)
      else $error("counter failed to wrap to zero");
endmodule // efs_counter

// File: tb/efs_partner.sv
/*
 Far-side model: receive MAC, transmit MAC and the readout requester.
 Assumes a free-running mclk; every output changes by NBA at posedge.
*/
`timescale 1ns/1ps
module efs_partner (
   // Clock and readout progress
   input  wire logic        mclk,
   input  wire logic        rd_done,
   // Frame status towards the counters
   output logic             rx_v,
   output logic [4:0]       rx_f,
   output logic [13:0]      rx_len,
   output logic             tx_v,
   output logic [6:0]       tx_f,
   output logic [4:0]       tx_col,
   // Readout request
   output logic             rd_req,
   output logic             rd_set
);
   // Quiet lines at time zero
   initial begin
      {rx_v, rx_f, rx_len, tx_v, tx_f, tx_col, rd_req, rd_set} = '0;
   end

   // One status cycle on both sides at once
   task automatic frame(input logic rv, input logic [4:0] rf,
      input logic [13:0] ln, input logic tv, input logic [6:0] tf,
      input logic [4:0] cl);
      @(posedge mclk);
      {rx_v, rx_f, rx_len} <= {rv, rf, ln};
      {tx_v, tx_f, tx_col} <= {tv, tf, cl};
   endtask

   // Idle: qualifiers drop and flags flip so stale flags are never trusted
   task automatic quiet();
      @(posedge mclk);
      {rx_v, tx_v} <= 2'h0;
      {rx_f, rx_len, tx_f, tx_col} <= ~{rx_f, rx_len, tx_f, tx_col};
   endtask

   // Request a set, retry with the other set while busy, await the end
   task automatic read_set(input logic s, output logic ok);
      ok = 1'h0;
      @(posedge mclk);
      rd_req <= 1'h1;
      rd_set <= s;
      @(posedge mclk);
      rd_req <= 1'h0;
      repeat (2) @(posedge mclk);
      rd_req <= 1'h1;
      rd_set <= ~s;
      @(posedge mclk);
      rd_req <= 1'h0;
      rd_set <= s;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge mclk);
         ok = rd_done;
      end
   endtask
endmodule // efs_partner

// File: tb/tb_ethernet_frame_statistics.sv
/*
 Self-checking bench for the statistics bank, narrow counters shrunk.
 Assumes the partner model drives all status and request inputs.
*/
`timescale 1ns/1ps
module tb_ethernet_frame_statistics;
   import efs_pkg::*;
   localparam int NW = 4;
   logic        mclk, sys_rst, rx_v, tx_v, rd_req, rd_set;
   logic        rd_valid, rd_done, rd_busy;
   logic [4:0]  rx_f, tx_col;
   logic [6:0]  tx_f;
   logic [13:0] rx_len, rx_max;
   logic [31:0] rd_data, erx[10], etx[12];
   logic [7:0]  rd_len;
   logic [32:0] expq[$];
   int          num_errors, checks_done;

   efs_partner p (.mclk(mclk), .rd_done(rd_done), .rx_v(rx_v),
      .rx_f(rx_f), .rx_len(rx_len), .tx_v(tx_v), .tx_f(tx_f),
      .tx_col(tx_col), .rd_req(rd_req), .rd_set(rd_set));

   efs_stats #(.RX_CNT_W(NW), .TX_CNT_W(NW)) dut (.mclk(mclk),
      .sys_rst(sys_rst), .rx_stat_valid(rx_v), .rx_crc_err(rx_f[0]),
      .rx_dribble(rx_f[1]), .rx_late_col(rx_f[2]),
      .rx_other_err(rx_f[3]), .rx_fifo_drop(rx_f[4]),
      .rx_frame_len(rx_len), .rx_max_len(rx_max),
      .tx_stat_valid(tx_v), .tx_ok(tx_f[6]), .tx_pause(tx_f[5]),
      .tx_col_cnt(tx_col), .tx_xs_col(tx_f[4]), .tx_late_col(tx_f[3]),
      .tx_underrun(tx_f[2]), .tx_xs_defer(tx_f[1]),
      .tx_carrier_err(tx_f[0]), .rd_req(rd_req), .rd_set(rd_set),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_len(rd_len),
      .rd_done(rd_done), .rd_busy(rd_busy));

   task automatic chk(input string n, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Narrow counters wrap at the shrunk width, good counters at 32
   function automatic logic [31:0] mk(input int i, input logic [31:0] v);
      return (i == 0) ? v : v & 32'((1 << NW) - 1);
   endfunction

   // Random frame pair; expected tallies follow the counting rules
   task automatic ev();
      logic [4:0]  rf;
      logic [6:0]  tf;
      logic [13:0] ln;
      logic [4:0]  cl;
      logic        rv, tv, err;
      {rf, tf, rv, tv} = 14'($urandom);
      cl = 5'($urandom % 4);
      ln = 14'(40 + $urandom % 1560);
      if (tf[6]) tf[0] = 1'h0;
      err = rf[0] | rf[2] | rf[3] | (ln > rx_max);
      if (rv && !err) erx[EFS_RX_GOOD]++;
      if (rv && rf[4]) erx[EFS_RX_DROP]++;
      if (rv && !rf[4] && err) begin
         erx[EFS_RX_BAD]++;
         erx[EFS_RX_CRC] += 32'(rf[0] & !rf[1]);
         erx[EFS_RX_ALIGN] += 32'(rf[0] & rf[1]);
         erx[EFS_RX_RUNT] += 32'(rf[0] && ln < EFS_MIN_FRAME);
         erx[EFS_RX_LONG] += 32'(ln > rx_max);
         erx[EFS_RX_LATE] += 32'(rf[2]);
      end
      if (tv && tf[6]) begin
         etx[tf[5] ? EFS_TX_PAUSE : EFS_TX_GOOD]++;
         etx[EFS_TX_SCOL] += 32'(cl == 1);
         etx[EFS_TX_MCOL] += 32'(cl > 1);
      end
      if (tv && !tf[6]) begin
         etx[EFS_TX_BAD]++;
         etx[EFS_TX_XCOL] += 32'(tf[4]);
         etx[EFS_TX_LCOL] += 32'(tf[3]);
         etx[EFS_TX_UNDR] += 32'(tf[2]);
         etx[EFS_TX_XDEF] += 32'(tf[1]);
         etx[EFS_TX_CARR] += 32'(tf[0]);
      end
      p.frame(rv, rf, ln, tv, tf, cl);
   endtask

   // Notes the snapshot, then keeps traffic flowing during the stream
   task automatic readout(input logic s);
      logic ok;
      for (int i = 0; i < (s ? 12 : 10); i++)
         expq.push_back({1'b0, mk(i, s ? etx[i] : erx[i])});
      fork
         p.read_set(s, ok);
         begin
            repeat (2) @(posedge mclk);
            repeat (6) ev();
            p.quiet();
         end
      join
      // One more edge so the watcher has taken the final word
      @(posedge mclk);
      chk("done seen", 1, ok);
      chk("length", s ? EFS_TX_LEN : EFS_RX_LEN, rd_len);
      chk("busy", 0, rd_busy);
      chk("notes left", 0, expq.size());
   endtask

   task automatic clear_exp();
      foreach (erx[i]) erx[i] = '0;
      foreach (etx[i]) etx[i] = '0;
   endtask

   // Result watcher: each streamed word is matched to the oldest note
   always @(posedge mclk) begin : watch
      logic [32:0] e;
      if (rd_valid === 1'h1) begin
         chk("note ready", 1, expq.size() != 0);
         e = (expq.size() != 0) ? expq.pop_front() : '0;
         if (!e[32]) chk("word", e[31:0], rd_data);
         chk("last", expq.size() == 0, rd_done);
         chk("busy", expq.size() != 0, rd_busy);
      end
   end

   // Clock
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   // Watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      complete_run();
   end

   // Main sequence
   initial begin
      {sys_rst, rx_max, num_errors, checks_done} = {1'h1, 14'h05ee, 64'h0};
      clear_exp();
      void'($urandom(21));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'h0;
      readout(1'h0);
      readout(1'h1);
      $display("test reset values done");
      repeat (4) begin
         @(posedge mclk);
         rx_max <= 14'(60 + $urandom % 1500);
         @(posedge mclk);
         repeat (60) ev();
         p.quiet();
         readout(1'h0);
         readout(1'h1);
      end
      $display("test random traffic done");
      @(posedge mclk);
      sys_rst <= 1'h1;
      clear_exp();
      repeat (2) @(posedge mclk);
      sys_rst <= 1'h0;
      readout(1'h1);
      readout(1'h0);
      $display("test second reset done");
      complete_run();
   end
endmodule // tb_ethernet_frame_statistics
